// file: design/ccs_counter_top.sv
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module ccs_counter_top
  import ccs_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Register port
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // Count sources
  input wire logic T0_OVF_I,
  input wire logic EXT_COUNT_I,
  input wire logic EXT_OSC_I,
  // Interrupts
  output logic OVF_IRQ_O,
  output logic IRQ_O
);

  logic rst_s1_reg;
  logic rst_n;
  ccs_bus_t bus;
  logic [7:0] mode_reg;
  logic [7:0] ctrl_reg;
  logic [15:0] cnt_reg;
  logic [3:0] pre_reg;
  logic [7:0] stat_reg;
  logic [7:0] mask_reg;
  logic [7:0] rdata_next;
  logic ext_tick;
  logic ext_fall;
  logic inc;
  logic pre_wrap;
  logic wrap;
  logic mode_we;
  logic ctrl_we;
  logic [7:0] stat_set;
  logic [7:0] stat_next;
  logic ovf_flag_next;
  logic mode_ie_next;
  logic [7:0] mask_next;
  ccs_src_t src;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

  ccs_ext_div8 u_div8 (
    .ext_clk_i(EXT_OSC_I),
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .tick_o(ext_tick)
  );

  ccs_edge_det u_edge (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .sig_i(EXT_COUNT_I),
    .fall_o(ext_fall)
  );

  function automatic logic hit(input ccs_bus_t b, input logic [3:0] a);
    return b.wr && (b.addr == a);
  endfunction : hit

  assign src = ccs_src_t'(mode_reg[CCS_MODE_SEL_LSB +: 3]);
  assign mode_we = hit(bus, CCS_ADDR_MODE) && !mode_reg[CCS_MODE_WDT_BIT];
  assign ctrl_we = hit(bus, CCS_ADDR_CTRL);

  // Enable and mask as they stand after this edge, so requests track writes
  assign mode_ie_next = mode_we ? bus.wdata[CCS_MODE_IE_BIT] : mode_reg[CCS_MODE_IE_BIT];
  assign mask_next = hit(bus, CCS_ADDR_IRQ_MASK) ? (bus.wdata & CCS_IRQ_IMPL) : mask_reg;

  // Prescaler wrap for the divided system clock options
  assign pre_wrap = (src == CCS_SRC_DIV12) ? (pre_reg == CCS_DIV12_LAST)
                                           : (pre_reg[1:0] == CCS_DIV4_LAST[1:0]);

  // Source decode
  always_comb begin
    unique case (src)
      CCS_SRC_DIV12: inc = pre_wrap;
      CCS_SRC_DIV4: inc = pre_wrap;
      CCS_SRC_T0OVF: inc = T0_OVF_I;
      CCS_SRC_EXTIN: inc = ext_fall;
      CCS_SRC_SYSCLK: inc = 1'b1;
      CCS_SRC_EXTDIV8: inc = ext_tick;
      default: inc = 1'b0;
    endcase
  end

  assign wrap = ctrl_reg[CCS_CTRL_RUN_BIT] && inc && (cnt_reg == CCS_CNT_MAX);
  // Hardware set wins over a software clear
  assign ovf_flag_next = wrap ? 1'b1
                       : ctrl_we ? bus.wdata[CCS_CTRL_OVF_BIT]
                       : ctrl_reg[CCS_CTRL_OVF_BIT];

  assign stat_set = {6'h00, ext_fall, wrap};
  assign stat_next = hit(bus, CCS_ADDR_IRQ_STAT)
                   ? ((stat_reg & ~bus.wdata) | stat_set) & CCS_IRQ_IMPL
                   : (stat_reg | stat_set) & CCS_IRQ_IMPL;

  always_comb begin
    unique case (bus.addr)
      CCS_ADDR_MODE: rdata_next = mode_reg;
      CCS_ADDR_CTRL: rdata_next = ctrl_reg;
      CCS_ADDR_CNT_LO: rdata_next = cnt_reg[7:0];
      CCS_ADDR_CNT_HI: rdata_next = cnt_reg[15:8];
      CCS_ADDR_IRQ_STAT: rdata_next = stat_reg;
      CCS_ADDR_IRQ_MASK: rdata_next = mask_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= CCS_MODE_RST;
      mask_reg <= 8'h00;
      stat_reg <= 8'h00;
      RDATA_O <= 8'h00;
    end else begin
      if (mode_we) begin
        mode_reg <= bus.wdata;
      end
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      RDATA_O <= bus.rd ? rdata_next : 8'h00;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CCS_CTRL_RST;
      cnt_reg <= CCS_CNT_RST;
      pre_reg <= 4'h0;
    end else begin
      pre_reg <= pre_wrap ? 4'h0 : pre_reg + 4'h1;
      if (ctrl_we) begin
        ctrl_reg <= bus.wdata;
      end
      ctrl_reg[CCS_CTRL_OVF_BIT] <= ovf_flag_next;
      if (hit(bus, CCS_ADDR_CNT_LO)) begin
        cnt_reg[7:0] <= bus.wdata;
      end else if (hit(bus, CCS_ADDR_CNT_HI)) begin
        cnt_reg[15:8] <= bus.wdata;
      end else if (ctrl_reg[CCS_CTRL_RUN_BIT] && inc) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  // Overflow request is the flag gated by the enable only
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      OVF_IRQ_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      OVF_IRQ_O <= ovf_flag_next & mode_ie_next;
      IRQ_O <= |(stat_next & mask_next);
    end
  end

  a_ovf_irq_gate: assert property (@(posedge CLK_I) disable iff (!rst_n)
    ctrl_reg[CCS_CTRL_OVF_BIT] && mode_reg[CCS_MODE_IE_BIT] |-> OVF_IRQ_O)
    else $error("overflow flag with enable gave no request");

  a_ovf_irq_mask: assert property (@(posedge CLK_I) disable iff (!rst_n)
    !mode_reg[CCS_MODE_IE_BIT] |-> !OVF_IRQ_O)
    else $error("masked overflow raised request");

  a_irq_only_flag: assert property (@(posedge CLK_I) disable iff (!rst_n)
    OVF_IRQ_O |-> ctrl_reg[CCS_CTRL_OVF_BIT])
    else $error("request without overflow flag");

  a_mode_lock: assert property (@(posedge CLK_I) disable iff (!rst_n)
    mode_reg[CCS_MODE_WDT_BIT] |=> $stable(mode_reg))
    else $error("mode register changed while locked");

  a_wrap_sets_flag: assert property (@(posedge CLK_I) disable iff (!rst_n)
    wrap |=> ctrl_reg[CCS_CTRL_OVF_BIT] && cnt_reg == CCS_CNT_RST)
    else $error("wrap did not set overflow flag");

  sequence s_ext_fall;
    src == CCS_SRC_EXTIN && ctrl_reg[CCS_CTRL_RUN_BIT] && ext_fall && !bus.wr;
  endsequence

  a_ext_edge_count: assert property (@(posedge CLK_I) disable iff (!rst_n)
    s_ext_fall |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("falling edge did not count");

  a_sysclk_count: assert property (@(posedge CLK_I) disable iff (!rst_n)
    src == CCS_SRC_SYSCLK && ctrl_reg[CCS_CTRL_RUN_BIT] && !bus.wr
    |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("system clock source did not count");

  a_div4_rate: assert property (@(posedge CLK_I) disable iff (!rst_n)
    src == CCS_SRC_DIV4 && inc |=> (!inc || src != CCS_SRC_DIV4) [*3])
    else $error("divide-by-four source counted too often");

  a_rsvd_hold: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (src == CCS_SRC_RSVD6 || src == CCS_SRC_RSVD7) |-> !inc)
    else $error("reserved source counted");

  a_ext_tick_pulse: assert property (@(posedge CLK_I) disable iff (!rst_n)
    ext_tick |=> !ext_tick)
    else $error("oscillator tick longer than one cycle");

  // Divided system clock sources keep their period
  sequence s_div12_run;
    (src == CCS_SRC_DIV12) [*8] ##1 (src == CCS_SRC_DIV12) [*4];
  endsequence

  a_div12_period: assert property (@(posedge CLK_I) disable iff (!rst_n)
    src == CCS_SRC_DIV12 && inc ##1 s_div12_run |-> inc)
    else $error("divide-by-twelve source missed a count");

  a_div12_rate: assert property (@(posedge CLK_I) disable iff (!rst_n)
    src == CCS_SRC_DIV12 && inc
    |=> (!inc || src != CCS_SRC_DIV12) [*8] ##1 (!inc || src != CCS_SRC_DIV12) [*3])
    else $error("divide-by-twelve source counted too often");

  a_div4_period: assert property (@(posedge CLK_I) disable iff (!rst_n)
    src == CCS_SRC_DIV4 && inc ##1 (src == CCS_SRC_DIV4) [*4] |-> inc)
    else $error("divide-by-four source missed a count");

  // Event sources advance the counter by one per event only
  sequence s_t0_event;
    src == CCS_SRC_T0OVF && ctrl_reg[CCS_CTRL_RUN_BIT] && T0_OVF_I && !bus.wr;
  endsequence

  a_t0_count: assert property (@(posedge CLK_I) disable iff (!rst_n)
    s_t0_event |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("timer overflow source did not count");

  a_t0_only: assert property (@(posedge CLK_I) disable iff (!rst_n)
    src == CCS_SRC_T0OVF && ctrl_reg[CCS_CTRL_RUN_BIT] && !T0_OVF_I && !bus.wr
    |=> $stable(cnt_reg))
    else $error("timer overflow source counted without an event");

  a_ext_only_fall: assert property (@(posedge CLK_I) disable iff (!rst_n)
    src == CCS_SRC_EXTIN && ctrl_reg[CCS_CTRL_RUN_BIT] && !ext_fall && !bus.wr
    |=> $stable(cnt_reg))
    else $error("external input counted without a falling edge");

  sequence s_osc_tick;
    src == CCS_SRC_EXTDIV8 && ctrl_reg[CCS_CTRL_RUN_BIT] && ext_tick && !bus.wr;
  endsequence

  a_osc_count: assert property (@(posedge CLK_I) disable iff (!rst_n)
    s_osc_tick |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("oscillator tick did not count");

  a_osc_only_tick: assert property (@(posedge CLK_I) disable iff (!rst_n)
    src == CCS_SRC_EXTDIV8 && ctrl_reg[CCS_CTRL_RUN_BIT] && !ext_tick && !bus.wr
    |=> $stable(cnt_reg))
    else $error("oscillator source counted without a tick");

  a_count_stopped: assert property (@(posedge CLK_I) disable iff (!rst_n)
    !ctrl_reg[CCS_CTRL_RUN_BIT] && !bus.wr |=> $stable(cnt_reg))
    else $error("counter moved while stopped");

  // Flags, interrupt level and lock
  a_flag_sticky: assert property (@(posedge CLK_I) disable iff (!rst_n)
    ctrl_reg[CCS_CTRL_OVF_BIT] && !ctrl_we |=> ctrl_reg[CCS_CTRL_OVF_BIT])
    else $error("overflow flag dropped without a write");

  a_stat_sticky: assert property (@(posedge CLK_I) disable iff (!rst_n)
    stat_reg[CCS_IRQ_OVF_BIT] && !(bus.wr && bus.addr == CCS_ADDR_IRQ_STAT)
    |=> stat_reg[CCS_IRQ_OVF_BIT])
    else $error("overflow status dropped without a clear");

  a_irq_level: assert property (@(posedge CLK_I) disable iff (!rst_n)
    IRQ_O == |(stat_reg & mask_reg))
    else $error("interrupt level differs from masked status");

  a_mode_write: assert property (@(posedge CLK_I) disable iff (!rst_n)
    bus.wr && bus.addr == CCS_ADDR_MODE && !mode_reg[CCS_MODE_WDT_BIT]
    |=> mode_reg == $past(bus.wdata))
    else $error("unlocked mode write did not land");

  a_rdata_idle: assert property (@(posedge CLK_I) disable iff (!rst_n)
    !bus.rd |=> RDATA_O == 8'h00)
    else $error("read data shown without a read");

endmodule : ccs_counter_top
`default_nettype wire

// file: pkg/ccs_pkg.sv
package ccs_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] CCS_ADDR_MODE = 4'h0;
  localparam logic [3:0] CCS_ADDR_CTRL = 4'h1;
  localparam logic [3:0] CCS_ADDR_CNT_LO = 4'h2;
  localparam logic [3:0] CCS_ADDR_CNT_HI = 4'h3;
  localparam logic [3:0] CCS_ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] CCS_ADDR_IRQ_MASK = 4'h5;

  // Mode register field positions
  localparam int CCS_MODE_IE_BIT = 0;
  localparam int CCS_MODE_SEL_LSB = 1;
  localparam int CCS_MODE_WDT_BIT = 6;
  // Control register field positions
  localparam int CCS_CTRL_OVF_BIT = 7;
  localparam int CCS_CTRL_RUN_BIT = 6;

  localparam logic [7:0] CCS_MODE_RST = 8'h00;
  localparam logic [7:0] CCS_CTRL_RST = 8'h00;
  localparam logic [15:0] CCS_CNT_RST = 16'h0000;
  localparam logic [15:0] CCS_CNT_MAX = 16'hFFFF;

  // Prescaler divide counts
  localparam logic [3:0] CCS_DIV12_LAST = 4'hB;
  localparam logic [3:0] CCS_DIV4_LAST = 4'h3;
  localparam logic [2:0] CCS_DIV8_LAST = 3'h7;

  // Interrupt status bit positions
  localparam int CCS_IRQ_OVF_BIT = 0;
  localparam int CCS_IRQ_EXT_BIT = 1;
  localparam logic [7:0] CCS_IRQ_IMPL = 8'h03;

  typedef enum logic [2:0] {
    CCS_SRC_DIV12 = 3'b000,
    CCS_SRC_DIV4 = 3'b001,
    CCS_SRC_T0OVF = 3'b010,
    CCS_SRC_EXTIN = 3'b011,
    CCS_SRC_SYSCLK = 3'b100,
    CCS_SRC_EXTDIV8 = 3'b101,
    CCS_SRC_RSVD6 = 3'b110,
    CCS_SRC_RSVD7 = 3'b111
  } ccs_src_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ccs_bus_t;

endpackage : ccs_pkg

// file: design/ccs_ext_div8.sv
`timescale 1ns/10ps
`default_nettype none
// Divide-by-eight on the external oscillator, carried into the system clock by a toggle synchroniser
module ccs_ext_div8
  import ccs_pkg::*;
(
  // External oscillator domain
  input wire logic ext_clk_i,
  // System domain
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic tick_o
);

  logic [2:0] div_reg;
  logic tgl_reg;
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic ext_rst1_reg;
  logic ext_rst2_reg;

  always_ff @(posedge ext_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_rst1_reg <= 1'b0;
      ext_rst2_reg <= 1'b0;
    end else begin
      ext_rst1_reg <= 1'b1;
      ext_rst2_reg <= ext_rst1_reg;
    end
  end

  // One toggle per eight oscillator cycles
  always_ff @(posedge ext_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= 3'h0;
      tgl_reg <= 1'b0;
    end else if (ext_rst2_reg) begin
      div_reg <= div_reg + 3'h1;
      if (div_reg == CCS_DIV8_LAST) begin
        tgl_reg <= ~tgl_reg;
      end
    end
  end

  // Toggle crossing; edge seen only past second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      s1_reg <= tgl_reg;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      tick_o <= s2_reg ^ s3_reg;
    end
  end

endmodule : ccs_ext_div8
`default_nettype wire

// file: design/ccs_edge_det.sv
`timescale 1ns/10ps
`default_nettype none
// Falling-edge pulse on a synchronous input
module ccs_edge_det (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sig_i,
  output logic fall_o
);

  logic prev_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= sig_i;
    end
  end

  assign fall_o = prev_reg & ~sig_i;

endmodule : ccs_edge_det
`default_nettype wire

// file: verification/ccs_counter_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ccs_counter_top_tb
  import ccs_pkg::*;
();
  localparam int RUN = 600;
  logic clk, rst_n, wr_s, rd_s, t0, ext_cnt, ext_osc, ovf_irq, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rv, lo_b, mode_m;
  int num_errors = 0;
  int n_tests = 0;
  int osc_n;
  bit osc_win;

  ccs_counter_top u_ccs_counter_top (
    .CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
    .RD_I(rd_s), .RDATA_O(rdata), .T0_OVF_I(t0), .EXT_COUNT_I(ext_cnt),
    .EXT_OSC_I(ext_osc), .OVF_IRQ_O(ovf_irq), .IRQ_O(irq)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Oscillator unrelated in phase to the system clock
  initial begin
    ext_osc = 1'b0;
    forever #37 ext_osc = ~ext_osc;
  end
  always @(posedge ext_osc) if (osc_win) osc_n++;

  task automatic test_done();
    $display("Counts: %0d compares, %0d errors", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi, input string what);
    n_tests++;
    if ($isunknown(got) || got < lo || got > hi) begin
      num_errors++;
      $display("ERROR %0t: %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : chk_rng

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    if (a == CCS_ADDR_MODE && !mode_m[6]) mode_m = d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // Count the selected source over RUN clocks; n_ev events only for the timer overflow and external input sources
  task automatic run_sel(input logic [2:0] sel, input int n_ev);
    int e, tol;
    wr(CCS_ADDR_CTRL, 8'h00);
    wr(CCS_ADDR_CNT_LO, 8'h00);
    wr(CCS_ADDR_CNT_HI, 8'h00);
    wr(CCS_ADDR_MODE, {4'h0, sel, 1'b0});
    osc_n = 0;
    wr(CCS_ADDR_CTRL, 8'h40);
    osc_win = 1'b1;
    for (int i = 0; i < RUN; i++) begin
      @(posedge clk);
      t0 <= (sel == 3'b010) && (i % 4 == 1) && (i < 4 * n_ev);
      ext_cnt <= !((sel == 3'b011) && (i % 4 < 2) && (i < 4 * n_ev));
    end
    osc_win = 1'b0;
    wr(CCS_ADDR_CTRL, 8'h00);
    t0 <= 1'b0;
    ext_cnt <= 1'b1;
    rd(CCS_ADDR_CNT_LO, lo_b);
    rd(CCS_ADDR_CNT_HI, rv);
    tol = 2;
    case (sel)
      3'b000: e = RUN / 12;
      3'b001: e = RUN / 4;
      3'b010, 3'b011: e = n_ev;
      3'b100: begin
        e = RUN;
        tol = 3;
      end
      3'b101: e = osc_n / 8;
      default: begin
        e = 0;
        tol = 0;
      end
    endcase
    chk_rng({rv, lo_b}, e - tol, e + tol, "count");
    $display("Test select %0d done", sel);
  endtask : run_sel

  initial begin
    #2000000;
    num_errors++;
    $display("ERROR %0t: timeout", $time);
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    t0 = 1'b0;
    ext_cnt = 1'b1;
    mode_m = CCS_MODE_RST;
    osc_win = 1'b0;
    osc_n = 0;
    void'($urandom(32'he148));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(CCS_ADDR_MODE, rv);
    chk8(rv, CCS_MODE_RST, "mode reset");
    rd(CCS_ADDR_CTRL, rv);
    chk8(rv, CCS_CTRL_RST, "ctrl reset");
    rd(4'h7, rv);
    chk8(rv, 8'h00, "unmapped");
    $display("Test reset done");
    for (int s = 0; s < 8; s++) run_sel(s[2:0], $urandom_range(3, 12));
    // Overflow with the enable clear, then set
    wr(CCS_ADDR_MODE, 8'h08);
    wr(CCS_ADDR_CNT_LO, 8'hFE);
    wr(CCS_ADDR_CNT_HI, 8'hFF);
    wr(CCS_ADDR_CTRL, 8'h40);
    repeat (8) @(posedge clk);
    chk8({7'h00, ovf_irq}, 8'h00, "masked request");
    rd(CCS_ADDR_CTRL, rv);
    chk8(rv & 8'h80, 8'h80, "overflow flag");
    rd(CCS_ADDR_IRQ_STAT, rv);
    chk8(rv & 8'h01, 8'h01, "status overflow");
    wr(CCS_ADDR_MODE, 8'h09);
    repeat (3) @(posedge clk);
    chk8({7'h00, ovf_irq}, 8'h01, "enabled request");
    wr(CCS_ADDR_IRQ_MASK, 8'h01);
    repeat (3) @(posedge clk);
    chk8({7'h00, irq}, 8'h01, "irq unmasked");
    wr(CCS_ADDR_IRQ_STAT, 8'h01);
    repeat (3) @(posedge clk);
    chk8({7'h00, irq}, 8'h00, "irq cleared");
    wr(CCS_ADDR_CTRL, 8'h40);
    repeat (3) @(posedge clk);
    chk8({7'h00, ovf_irq}, 8'h00, "flag cleared");
    $display("Test interrupt done");
    // Watchdog lock on the mode register
    wr(CCS_ADDR_MODE, 8'h41);
    rd(CCS_ADDR_MODE, rv);
    chk8(rv, mode_m, "mode lock set");
    wr(CCS_ADDR_MODE, 8'h0B);
    rd(CCS_ADDR_MODE, rv);
    chk8(rv, mode_m, "mode locked");
    $display("Test lock done");
    test_done();
  end
endmodule : ccs_counter_top_tb
`default_nettype wire
